// >>> verilog/eag_addr_gen.v
// Address generation, software stack and secure RAM gating for the CPU
`timescale 1ns/100ps
`include "eag_map.vh"

module eag_addr_gen
#(
  parameter        W     = 16,
  parameter [15:0] BS_LO = 16'h0800,
  parameter [15:0] BS_HI = 16'h087F,
  parameter [15:0] SS_LO = 16'h0880,
  parameter [15:0] SS_HI = 16'h08FF
)
(
  input  wire          i_clk,
  input  wire          i_sys_rst,
  input  wire          i_op_valid,
  input  wire [2:0]    i_src_mode,
  input  wire [15:0]   i_src_ptr,
  input  wire          i_src_ptr_is_sp,
  input  wire [15:0]   i_src_mod,
  input  wire [2:0]    i_dst_mode,
  input  wire [15:0]   i_dst_ptr,
  input  wire          i_dst_ptr_is_sp,
  input  wire [15:0]   i_dst_mod,
  input  wire [3:0]    i_offset_idx,
  input  wire [15:0]   i_offset_val,
  input  wire [12:0]   i_file_addr,
  input  wire          i_file_to_default_working_reg,
  input  wire [15:0]   i_op1_val,
  input  wire [1:0]    i_op2_sel,
  input  wire [15:0]   i_op2_reg,
  input  wire [9:0]    i_lit10,
  input  wire          i_call_push,
  input  wire          i_exc_push,
  input  wire [22:0]   i_pc,
  input  wire [7:0]    i_status_low_byte,
  input  wire          i_sp_we,
  input  wire [15:0]   i_sp_wdata,
  input  wire          i_stack_limit_reg_we,
  input  wire [15:0]   i_stack_limit_reg_wdata,
  input  wire          i_mac_valid,
  input  wire [3:0]    i_mac_idx_a,
  input  wire [15:0]   i_mac_val_a,
  input  wire [2:0]    i_mac_mode_a,
  input  wire [3:0]    i_mac_idx_b,
  input  wire [15:0]   i_mac_val_b,
  input  wire [2:0]    i_mac_mode_b,
  input  wire [15:0]   i_mac_off,
  input  wire [15:0]   i_bra_lit,
  input  wire [13:0]   i_interrupt_disable_instr_lit,
  input  wire          i_exec_boot,
  input  wire          i_exec_secure,
  input  wire          i_boot_secure_ram_ctl_en,
  input  wire          i_secure_segment_ram_ctl_en,
  output reg  [15:0]   o_src_ea,
  output reg  [15:0]   o_dst_ea,
  output reg           o_src_mem,
  output reg           o_dst_mem,
  output reg  [15:0]   o_src_wb_val,
  output reg           o_src_wb_en,
  output reg  [15:0]   o_dst_wb_val,
  output reg           o_dst_wb_en,
  output reg  [3:0]    o_offset_idx,
  output reg           o_dst_is_default_working_reg,
  output reg  [3:0]    o_dst_reg_idx,
  output reg  [15:0]   o_op1,
  output reg  [15:0]   o_op2,
  output reg           o_op2_from_mem,
  output reg           o_push_en,
  output reg  [15:0]   o_push_data,
  output reg  [15:0]   o_sp,
  output reg  [15:0]   o_stack_limit,
  output reg           o_stack_err,
  output reg           o_ram_fault,
  output reg           o_busy,
  output reg           o_mac_valid,
  output reg  [15:0]   o_x_rd_addr,
  output reg  [15:0]   o_y_rd_addr,
  output reg  [3:0]    o_x_wb_idx,
  output reg  [15:0]   o_x_wb_val,
  output reg           o_x_wb_en,
  output reg  [3:0]    o_y_wb_idx,
  output reg  [15:0]   o_y_wb_val,
  output reg           o_y_wb_en,
  output reg  [22:0]   o_branch_target,
  output reg  [13:0]   o_interrupt_disable_instr_count
);

  // ****************************************************************
  // State and stack registers
  // ****************************************************************
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_PCHI = 2'b10;

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [15:0] stack_pointer_default_working_reg;
  reg  [15:0] next_sp;
  reg  [15:0] stack_limit_reg;
  reg  [15:0] pc_hi_word;
  reg  [15:0] next_pc_hi_word;

  // No reset: the limit is undefined until software loads it
  always @(posedge i_clk)
  begin
    if (i_stack_limit_reg_we)
    begin
      stack_limit_reg <= {i_stack_limit_reg_wdata[15:1], 1'b0};       // RULE5
      o_stack_limit   <= {i_stack_limit_reg_wdata[15:1], 1'b0};
    end
  end

  // ****************************************************************
  // Address calculators
  // ****************************************************************
  wire [15:0] src_ptr = i_src_ptr_is_sp ? stack_pointer_default_working_reg : i_src_ptr;
  wire [15:0] dst_ptr = i_dst_ptr_is_sp ? stack_pointer_default_working_reg : i_dst_ptr;
  wire [15:0] src_ea;
  wire [15:0] dst_ea;
  wire [15:0] src_nxt;
  wire [15:0] dst_nxt;
  wire        src_upd;
  wire        dst_upd;
  wire        src_mem;
  wire        dst_mem;

  // One offset value feeds both sides of a move
  eag_ea_unit #(.W(W)) u_src                                // RULE17
  (
    .i_mode     (i_src_mode),
    .i_ptr      (src_ptr),
    .i_mod      (i_src_mod),
    .i_base     (i_offset_val),
    .i_file     (i_file_addr),
    .o_ea       (src_ea),
    .o_ptr_next (src_nxt),
    .o_ptr_upd  (src_upd),
    .o_mem      (src_mem)
  );

  eag_ea_unit #(.W(W)) u_dst
  (
    .i_mode     (i_dst_mode),
    .i_ptr      (dst_ptr),
    .i_mod      (i_dst_mod),
    .i_base     (i_offset_val),
    .i_file     (i_file_addr),
    .o_ea       (dst_ea),
    .o_ptr_next (dst_nxt),
    .o_ptr_upd  (dst_upd),
    .o_mem      (dst_mem)
  );

  // ****************************************************************
  // Dual-operand prefetch routing
  // ****************************************************************
  function [2:0] mac_mode;
    input [2:0] code;
    begin
      if (code == `EAG_MAC_IND)
        mac_mode = `EAG_M_IND;
      else if (code == `EAG_MAC_IDX)
        mac_mode = `EAG_M_INDEX;
      else
        mac_mode = `EAG_M_POST;
    end
  endfunction

  // Codes 1..3 step +2/+4/+6, codes 4..6 step -2/-4/-6
  function [15:0] mac_step;
    input [2:0] code;
    begin
      case (code)
        3'h1:    mac_step = 16'h0002;                       // RULE19
        3'h2:    mac_step = 16'h0004;
        3'h3:    mac_step = 16'h0006;
        3'h4:    mac_step = 16'hFFFE;
        3'h5:    mac_step = 16'hFFFC;
        3'h6:    mac_step = 16'hFFFA;
        default: mac_step = 16'h0000;
      endcase
    end
  endfunction

  wire a_is_x = (i_mac_idx_a == `EAG_PFX_X_LO) || (i_mac_idx_a == `EAG_PFX_X_HI);
  wire b_is_x = (i_mac_idx_b == `EAG_PFX_X_LO) || (i_mac_idx_b == `EAG_PFX_X_HI);
  wire b_is_y = (i_mac_idx_b == `EAG_PFX_Y_LO) || (i_mac_idx_b == `EAG_PFX_Y_HI);
  wire a_is_y = (i_mac_idx_a == `EAG_PFX_Y_LO) || (i_mac_idx_a == `EAG_PFX_Y_HI);
  wire x_from_a = a_is_x;                                   // RULE18
  wire x_ok     = a_is_x | b_is_x;
  wire y_from_a = a_is_y & ~b_is_y;                         // RULE18
  wire y_ok     = a_is_y | b_is_y;
  wire [3:0]  x_idx  = x_from_a ? i_mac_idx_a : i_mac_idx_b;
  wire [15:0] x_ptr  = x_from_a ? i_mac_val_a : i_mac_val_b;
  wire [2:0]  x_code = x_from_a ? i_mac_mode_a : i_mac_mode_b;
  wire [3:0]  y_idx  = y_from_a ? i_mac_idx_a : i_mac_idx_b;
  wire [15:0] y_ptr  = y_from_a ? i_mac_val_a : i_mac_val_b;
  wire [2:0]  y_code = y_from_a ? i_mac_mode_a : i_mac_mode_b;
  wire [15:0] x_ea;
  wire [15:0] y_ea;
  wire [15:0] x_nxt;
  wire [15:0] y_nxt;
  wire        x_upd;
  wire        y_upd;

  eag_ea_unit #(.W(W)) u_xrd
  (
    .i_mode     (mac_mode(x_code)),
    .i_ptr      (x_ptr),
    .i_mod      (mac_step(x_code)),
    .i_base     (i_mac_off),
    .i_file     (13'h0000),
    .o_ea       (x_ea),
    .o_ptr_next (x_nxt),
    .o_ptr_upd  (x_upd),
    .o_mem      ()
  );

  eag_ea_unit #(.W(W)) u_yrd
  (
    .i_mode     (mac_mode(y_code)),
    .i_ptr      (y_ptr),
    .i_mod      (mac_step(y_code)),
    .i_base     (i_mac_off),
    .i_file     (13'h0000),
    .o_ea       (y_ea),
    .o_ptr_next (y_nxt),
    .o_ptr_upd  (y_upd),
    .o_mem      ()
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  function stk_bad;
    input [15:0] ea;
    begin
      stk_bad = (ea > stack_limit_reg) || (ea < `EAG_SFR_TOP); // RULE7 RULE8
    end
  endfunction

  function ram_bad;
    input [15:0] ea;
    begin
      ram_bad = (i_boot_secure_ram_ctl_en && ea >= BS_LO && ea <= BS_HI && !i_exec_boot)  // RULE10
             || (i_secure_segment_ram_ctl_en && ea >= SS_LO && ea <= SS_HI && !i_exec_secure); // RULE11
    end
  endfunction

  wire [15:0] push_lo = i_pc[15:0];
  wire [15:0] push_hi = i_exc_push ? {i_status_low_byte, 1'b0, i_pc[22:16]} // RULE4
                                   : {8'h00, 1'b0, i_pc[22:16]};          // RULE3
  wire pc_push  = (i_call_push | i_exc_push) & state[0];
  wire in_pchi  = state[1];
  wire op_go    = i_op_valid & state[0] & ~pc_push;
  wire src_sp   = op_go & i_src_ptr_is_sp & src_mem;
  wire dst_sp   = op_go & i_dst_ptr_is_sp & dst_mem;
  wire stk_err  = ((pc_push | in_pchi) & stk_bad(stack_pointer_default_working_reg))
                | (src_sp & stk_bad(src_ea))                // RULE6
                | (dst_sp & stk_bad(dst_ea));

  // ****************************************************************
  // Next state
  // ****************************************************************
  always @*
  begin
    next_state      = state;
    next_sp         = stack_pointer_default_working_reg;
    next_pc_hi_word = pc_hi_word;
    case (state)
      ST_IDLE:
      begin
        if (pc_push)
        begin
          next_sp         = stack_pointer_default_working_reg + `EAG_WORD_STEP; // RULE2
          next_pc_hi_word = push_hi;
          next_state      = ST_PCHI;
        end
        else if (op_go)
        begin
          // Pop uses pre-decrement, push post-increment
          if (i_src_ptr_is_sp && src_upd)
            next_sp = src_nxt;                              // RULE2
          if (i_dst_ptr_is_sp && dst_upd)
            next_sp = dst_nxt;
        end
      end
      ST_PCHI:
      begin
        next_sp    = stack_pointer_default_working_reg + `EAG_WORD_STEP;
        next_state = ST_IDLE;
      end
      default:
        next_state = ST_IDLE;
    endcase
    if (i_sp_we)
      next_sp = i_sp_wdata;
    next_sp[0] = 1'b0;                                      // RULE1
  end

  // ****************************************************************
  // Output registers
  // ****************************************************************
  always @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state              <= ST_IDLE;
      stack_pointer_default_working_reg <= `EAG_SP_RESET;
      pc_hi_word         <= 16'h0000;
      o_src_ea           <= 16'h0000;
      o_dst_ea           <= 16'h0000;
      o_src_mem          <= 1'b0;
      o_dst_mem          <= 1'b0;
      o_src_wb_val       <= 16'h0000;
      o_src_wb_en        <= 1'b0;
      o_dst_wb_val       <= 16'h0000;
      o_dst_wb_en        <= 1'b0;
      o_offset_idx       <= 4'h0;
      o_dst_is_default_working_reg      <= 1'b0;
      o_dst_reg_idx      <= 4'h0;
      o_op1              <= 16'h0000;
      o_op2              <= 16'h0000;
      o_op2_from_mem     <= 1'b0;
      o_push_en          <= 1'b0;
      o_push_data        <= 16'h0000;
      o_sp               <= `EAG_SP_RESET;
      o_stack_err        <= 1'b0;
      o_ram_fault        <= 1'b0;
      o_busy             <= 1'b0;
      o_mac_valid        <= 1'b0;
      o_x_rd_addr        <= 16'h0000;
      o_y_rd_addr        <= 16'h0000;
      o_x_wb_idx         <= 4'h0;
      o_x_wb_val         <= 16'h0000;
      o_x_wb_en          <= 1'b0;
      o_y_wb_idx         <= 4'h0;
      o_y_wb_val         <= 16'h0000;
      o_y_wb_en          <= 1'b0;
      o_branch_target    <= 23'h000000;
      o_interrupt_disable_instr_count       <= 14'h0000;
    end
    else
    begin
      state              <= next_state;
      stack_pointer_default_working_reg <= next_sp;
      pc_hi_word         <= next_pc_hi_word;
      o_sp               <= next_sp;
      o_busy             <= next_state[1];
      o_push_en          <= pc_push | in_pchi;
      o_push_data        <= in_pchi ? pc_hi_word : push_lo;
      o_src_ea           <= src_ea;
      o_dst_ea           <= (pc_push | in_pchi) ? stack_pointer_default_working_reg : dst_ea;
      o_src_mem          <= op_go & src_mem;
      o_dst_mem          <= op_go & dst_mem;
      o_src_wb_val       <= src_nxt;
      o_src_wb_en        <= op_go & src_upd & ~i_src_ptr_is_sp;
      o_dst_wb_val       <= dst_nxt;
      o_dst_wb_en        <= op_go & dst_upd & ~i_dst_ptr_is_sp;
      o_offset_idx       <= i_offset_idx;                   // RULE17
      o_dst_is_default_working_reg      <= op_go & i_file_to_default_working_reg;
      o_dst_reg_idx      <= `EAG_DEF_DEFAULT_WORKING_REG;                  // RULE13
      o_op1              <= i_op1_val;                      // RULE14
      case (i_op2_sel)
        `EAG_OP2_L5:  o_op2 <= {11'h000, i_lit10[4:0]};     // RULE14
        `EAG_OP2_L10: o_op2 <= {6'h00, i_lit10};
        default:      o_op2 <= i_op2_reg;
      endcase
      o_op2_from_mem     <= op_go & (i_op2_sel == `EAG_OP2_MEM);
      o_stack_err        <= stk_err;                        // RULE21
      o_ram_fault        <= (op_go & src_mem & ram_bad(src_ea))
                          | (op_go & dst_mem & ram_bad(dst_ea))
                          | (i_mac_valid & x_ok & ram_bad(x_ea))
                          | (i_mac_valid & y_ok & ram_bad(y_ea));
      o_mac_valid        <= i_mac_valid & x_ok & y_ok;
      o_x_rd_addr        <= x_ea;
      o_y_rd_addr        <= y_ea;
      o_x_wb_idx         <= x_idx;
      o_x_wb_val         <= x_nxt;
      o_x_wb_en          <= i_mac_valid & x_ok & x_upd;
      o_y_wb_idx         <= y_idx;
      o_y_wb_val         <= y_nxt;
      o_y_wb_en          <= i_mac_valid & y_ok & y_upd;
      o_branch_target    <= i_pc + {{6{i_bra_lit[15]}}, i_bra_lit, 1'b0}; // RULE20
      o_interrupt_disable_instr_count       <= i_interrupt_disable_instr_lit;                     // RULE20
    end
  end

endmodule

// >>> verilog/eag_map.vh
// Constants for the effective address generator and stack checker
// How it works
// RULE1: Stack pointer holds first free word; stack grows upward.
// RULE2: Pop decrements pointer before access; push increments it after access.
// RULE3: Call pushes of the program counter clear its top bit.
// RULE4: Exception pushes place the low status byte above the program counter bits.
// RULE5: Stack limit has no reset value; its bit 0 is always zero.
// RULE6: Every stack-pointer effective address is compared with the stack limit.
// RULE7: Push at pointer equal to limit passes; the following push traps.
// RULE8: Stack addresses below 0x0800 raise the stack error trap.
// RULE9: Software avoids a stack-pointer indirect read right after a limit write.
// RULE10: Enabled boot secure RAM accepts only boot segment code; program counter stack pushes are not checked.
// RULE11: Enabled secure segment RAM accepts only secure segment code; program counter stack pushes are not checked.
// RULE12: File register direct uses a 13-bit field, lowest 8192 bytes.
// RULE13: File instructions default to working register 0; write file or it.
// RULE14: First operand is a direct register; second register, memory or literal.
// RULE15: Indirect uses pointer; post adds after use, pre adds signed before.
// RULE16: Indexed adds base register; literal offset adds a literal.
// RULE17: Moves take separate source and destination modes, one shared offset field.
// RULE18: Prefetch pointers 8 and 9 go to X, 10 and 11 to Y.
// RULE19: Dual-operand reads use indirect, indexed, post-modify by 2, 4 or 6; the code also post-decrements by 2, 4 or 6.
// RULE20: Branch uses 16-bit signed literal; interrupt disable a 14-bit literal.
// RULE21: Stack error is a one-cycle request with the offending address.
`ifndef EAG_MAP_VH
`define EAG_MAP_VH

// Addressing modes
`define EAG_M_DIRECT 3'h0
`define EAG_M_IND    3'h1
`define EAG_M_POST   3'h2
`define EAG_M_PRE    3'h3
`define EAG_M_INDEX  3'h4
`define EAG_M_LITOFF 3'h5
`define EAG_M_FILE   3'h6

// Second operand sources
`define EAG_OP2_REG  2'h0
`define EAG_OP2_MEM  2'h1
`define EAG_OP2_L5   2'h2
`define EAG_OP2_L10  2'h3

// Dual-operand read mode codes
`define EAG_MAC_IND  3'h0
`define EAG_MAC_IDX  3'h7

`define EAG_FILE_W      13
`define EAG_SFR_TOP     16'h0800
`define EAG_DEF_DEFAULT_WORKING_REG    4'h0
`define EAG_WORD_STEP   16'h0002
`define EAG_PFX_X_LO    4'h8
`define EAG_PFX_X_HI    4'h9
`define EAG_PFX_Y_LO    4'hA
`define EAG_PFX_Y_HI    4'hB
`define EAG_SP_RESET    16'h0800

`endif

// >>> verilog/eag_ea_unit.v
// One effective address calculator for a single pointer
`timescale 1ns/100ps
`include "eag_map.vh"

module eag_ea_unit
#(
  parameter W = 16
)
(
  input  wire [2:0]   i_mode,
  input  wire [W-1:0] i_ptr,
  input  wire [W-1:0] i_mod,
  input  wire [W-1:0] i_base,
  input  wire [12:0]  i_file,
  output reg  [W-1:0] o_ea,
  output reg  [W-1:0] o_ptr_next,
  output reg          o_ptr_upd,
  output reg          o_mem
);

  always @*
  begin
    o_ea       = i_ptr;
    o_ptr_next = i_ptr;
    o_ptr_upd  = 1'b0;
    o_mem      = 1'b1;
    case (i_mode)
      `EAG_M_IND:
        o_ea = i_ptr;                                       // RULE15
      `EAG_M_POST:
      begin
        o_ea       = i_ptr;                                 // RULE15
        o_ptr_next = i_ptr + i_mod;
        o_ptr_upd  = 1'b1;
      end
      `EAG_M_PRE:
      begin
        o_ptr_next = i_ptr + i_mod;                         // RULE15
        o_ea       = i_ptr + i_mod;
        o_ptr_upd  = 1'b1;
      end
      `EAG_M_INDEX:
        o_ea = i_ptr + i_base;                              // RULE16
      `EAG_M_LITOFF:
        o_ea = i_ptr + i_mod;                               // RULE16
      `EAG_M_FILE:
        o_ea = {{(W-`EAG_FILE_W){1'b0}}, i_file};           // RULE12
      default:
        o_mem = 1'b0;
    endcase
  end

endmodule

// >>> tb/eag_addr_gen_chk.sv
// Port assertions for the address generator and stack checker
`timescale 1ns/100ps
`include "eag_map.vh"
module eag_addr_gen_chk
(
  input logic        i_clk,
  input logic        i_sys_rst,
  input logic        i_op_valid,
  input logic [2:0]  i_src_mode,
  input logic        i_src_ptr_is_sp,
  input logic [15:0] i_src_mod,
  input logic [2:0]  i_dst_mode,
  input logic        i_dst_ptr_is_sp,
  input logic [15:0] i_dst_mod,
  input logic        i_call_push,
  input logic        i_exc_push,
  input logic [22:0] i_pc,
  input logic [7:0]  i_status_low_byte,
  input logic        i_sp_we,
  input logic        i_stack_limit_reg_we,
  input logic [15:0] i_stack_limit_reg_wdata,
  input logic [15:0] o_src_ea,
  input logic [15:0] o_dst_ea,
  input logic        o_src_mem,
  input logic        o_dst_mem,
  input logic        o_push_en,
  input logic [15:0] o_push_data,
  input logic [15:0] o_sp,
  input logic [15:0] o_stack_limit,
  input logic        o_stack_err,
  input logic        o_busy
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // ****************************************
  // Stack sequences and properties
  // ****************************************
  sequence s_idle;
    !o_busy && !i_call_push && !i_exc_push && !i_sp_we && i_op_valid;
  endsequence
  sequence s_push;
    i_dst_mode == `EAG_M_POST && i_dst_ptr_is_sp && i_dst_mod == 16'h0002
      && !i_src_ptr_is_sp;
  endsequence
  sequence s_pop;
    i_src_mode == `EAG_M_PRE && i_src_ptr_is_sp && i_src_mod == 16'hFFFE
      && !i_dst_ptr_is_sp;
  endsequence
  sequence s_lo_word;
    o_push_en && o_busy && o_push_data == ($past(i_pc) & 23'h00FFFF);
  endsequence

  property p_lim;
    i_stack_limit_reg_we |=> o_stack_limit == ($past(i_stack_limit_reg_wdata) & 16'hFFFE);
  endproperty
  property p_push;
    s_idle ##0 s_push |=> o_dst_mem && o_dst_ea == $past(o_sp)
      && o_sp == $past(o_sp) + 16'h0002;
  endproperty
  property p_pop;
    s_idle ##0 s_pop |=> o_src_mem && o_src_ea == $past(o_sp) - 16'h0002
      && o_sp == o_src_ea;
  endproperty
  property p_push_err;
    s_idle ##0 s_push |=> o_stack_err ==
      ($past(o_sp) > o_stack_limit || $past(o_sp) < `EAG_SFR_TOP);
  endproperty
  property p_pop_err;
    s_idle ##0 s_pop |=> o_stack_err ==
      (o_src_ea > o_stack_limit || o_src_ea < `EAG_SFR_TOP);
  endproperty
  property p_call;
    !o_busy && i_call_push && !i_exc_push |=> s_lo_word ##1
      (o_push_en && !o_busy && o_push_data == ($past(i_pc, 2) >> 16));
  endproperty
  property p_exc;
    !o_busy && i_exc_push && !i_call_push |=> s_lo_word ##1 (o_push_en
      && o_push_data == ({$past(i_status_low_byte, 2), 8'h00} | ($past(i_pc, 2) >> 16)));
  endproperty
  property p_cause;
    o_stack_err |-> o_push_en || o_src_mem || o_dst_mem;
  endproperty

  a_lim: assert property (p_lim) else $error("limit bit 0 not clear");
  a_push: assert property (p_push) else $error("push address wrong");
  a_pop: assert property (p_pop) else $error("pop address wrong");
  a_push_err: assert property (p_push_err) else $error("push error wrong");
  a_pop_err: assert property (p_pop_err) else $error("pop error wrong");
  a_call: assert property (p_call) else $error("call push wrong");
  a_exc: assert property (p_exc) else $error("exception push wrong");
  a_cause: assert property (p_cause) else $error("stray stack error");
endmodule

bind eag_addr_gen eag_addr_gen_chk u_chk (.*);

// >>> tb/eag_far_mem.sv
// Data memory model that takes the program counter stack pushes
`timescale 1ns/100ps
module eag_far_mem
(
  input logic        i_clk,
  input logic        i_wr_en,
  input logic [15:0] i_addr,
  input logic [15:0] i_wdata
);
  logic [15:0] mem [0:255];

  // Word-addressed store
  always @(posedge i_clk)
  begin
    if (i_wr_en)
      mem[i_addr[8:1]] <= i_wdata;
  end
endmodule

// >>> tb/eag_addr_gen_test.sv
// Self-checking testbench for the address generator
`timescale 1ns/100ps
`include "eag_map.vh"
module eag_addr_gen_test;
  localparam [15:0] BS = 16'h0800;
  localparam [15:0] SS = 16'h0880;
  logic        i_clk = 0, i_sys_rst = 1, i_op_valid = 0, i_src_ptr_is_sp = 0;
  logic        i_dst_ptr_is_sp = 0, i_file_to_default_working_reg = 0, i_call_push = 0, i_exc_push = 0;
  logic        i_sp_we = 0, i_stack_limit_reg_we = 0, i_mac_valid = 0, i_exec_boot = 0;
  logic        i_exec_secure = 0, i_boot_secure_ram_ctl_en = 0, i_secure_segment_ram_ctl_en = 0;
  logic [2:0]  i_src_mode = 0, i_dst_mode = 0, i_mac_mode_a = 0, i_mac_mode_b = 0;
  logic [15:0] i_src_ptr = 0, i_src_mod = 0, i_dst_ptr = 0, i_dst_mod = 0;
  logic [15:0] i_offset_val = 0, i_op1_val = 0, i_op2_reg = 0, i_sp_wdata = 0;
  logic [15:0] i_stack_limit_reg_wdata = 0, i_bra_lit = 0, i_mac_val_a = 0, i_mac_val_b = 0;
  logic [15:0] i_mac_off = 0;
  logic [3:0]  i_offset_idx = 0, i_mac_idx_a = 0, i_mac_idx_b = 0;
  logic [12:0] i_file_addr = 0;
  logic [1:0]  i_op2_sel = 0;
  logic [9:0]  i_lit10 = 0;
  logic [22:0] i_pc = 0;
  logic [7:0]  i_status_low_byte = 0;
  logic [13:0] i_interrupt_disable_instr_lit = 0;
  wire  [15:0] o_src_ea, o_dst_ea, o_src_wb_val, o_dst_wb_val, o_op1, o_op2;
  wire  [15:0] o_push_data, o_sp, o_stack_limit, o_x_rd_addr, o_y_rd_addr;
  wire  [15:0] o_x_wb_val, o_y_wb_val;
  wire         o_src_mem, o_dst_mem, o_src_wb_en, o_dst_wb_en, o_dst_is_default_working_reg;
  wire         o_op2_from_mem, o_push_en, o_stack_err, o_ram_fault, o_busy;
  wire         o_mac_valid, o_x_wb_en, o_y_wb_en;
  wire  [3:0]  o_offset_idx, o_dst_reg_idx, o_x_wb_idx, o_y_wb_idx;
  wire  [22:0] o_branch_target;
  wire  [13:0] o_interrupt_disable_instr_count;
  int          mismatches = 0;
  int          checks_done = 0;

  eag_addr_gen #(.BS_LO(BS), .SS_LO(SS)) dut (.*);

  eag_far_mem u_mem
  (
    .i_clk   (i_clk),
    .i_wr_en (o_push_en),
    .i_addr  (o_dst_ea),
    .i_wdata (o_push_data)
  );

  always #5 i_clk = ~i_clk;

  // ****************************************
  // Shared tasks
  // ****************************************
  task ck(input string n, input logic [22:0] e, input logic [22:0] g);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task go(input bit mac);
    @(negedge i_clk);
    i_op_valid = !mac;
    i_mac_valid = mac;
    @(negedge i_clk);
    i_op_valid = 0;
    i_mac_valid = 0;
  endtask

  task wr(input bit lim, input logic [15:0] v);
    @(negedge i_clk);
    i_sp_we = !lim;
    i_stack_limit_reg_we = lim;
    i_sp_wdata = v;
    i_stack_limit_reg_wdata = v;
    @(negedge i_clk);
    i_sp_we = 0;
    i_stack_limit_reg_we = 0;
    ck(lim ? "limit" : "sp", v & 16'hFFFE, lim ? o_stack_limit : o_sp);
  endtask

  task t_stack;
    logic [15:0] ea;
    wr(0, 16'h0800);
    wr(1, 16'h0805);
    i_dst_mode = `EAG_M_POST;
    i_dst_ptr_is_sp = 1;
    i_dst_mod = 16'h0002;
    for (int k = 0; k < 4; k++)
    begin
      ea = 16'h0800 + 16'(2 * k);
      go(0);
      ck("push ea", ea, o_dst_ea);
      ck("push sp", ea + 16'h0002, o_sp);
      ck("push err", k == 3, o_stack_err);
    end
    i_dst_mode = `EAG_M_DIRECT;
    i_dst_ptr_is_sp = 0;
    i_src_mode = `EAG_M_PRE;
    i_src_ptr_is_sp = 1;
    i_src_mod = 16'hFFFE;
    for (int k = 0; k < 2; k++)
    begin
      wr(0, k ? 16'h0800 : 16'h0804);
      go(0);
      ea = k ? 16'h07FE : 16'h0802;
      ck("pop ea", ea, o_src_ea);
      ck("pop sp", ea, o_sp);
      ck("pop err", k, o_stack_err);
    end
    i_src_ptr_is_sp = 0;
  endtask

  task t_pc;
    logic [15:0] up;
    wr(0, 16'h0810);
    wr(1, 16'h0FFE);
    i_pc = 23'h7F1234;
    i_status_low_byte = 8'hA5;
    for (int k = 0; k < 2; k++)
    begin
      up = k ? 16'hA57F : 16'h007F;
      @(negedge i_clk);
      i_call_push = !k;
      i_exc_push = k;
      @(negedge i_clk);
      i_call_push = 0;
      i_exc_push = 0;
      ck("push lo", 16'h1234, o_push_data);
      ck("push ea", 16'h0810 + 16'(4 * k), o_dst_ea);
      @(negedge i_clk);
      ck("push hi", up, o_push_data);
      ck("sp", 16'h0814 + 16'(4 * k), o_sp);
      @(negedge i_clk);
      ck("mem hi", up, u_mem.mem[8'h09 + 8'(2 * k)]);
    end
  endtask

  task t_modes;
    logic [15:0] ea [7] = '{0, 16'h1000, 16'h1000, 16'h0FFA, 16'h1020, 16'h0FFA, 16'h1FFE};
    logic [15:0] op2 [4] = '{16'h2468, 0, 16'h0015, 16'h03F5};
    i_src_ptr = 16'h1000;
    i_src_mod = 16'hFFFA;
    i_offset_idx = 4'h3;
    i_offset_val = 16'h0020;
    i_dst_mode = `EAG_M_INDEX;
    i_dst_ptr = 16'h2000;
    i_file_addr = 13'h1FFE;
    i_file_to_default_working_reg = 1;
    i_op1_val = 16'h1357;
    i_op2_reg = 16'h2468;
    i_lit10 = 10'h3F5;
    i_pc = 23'h000100;
    i_bra_lit = 16'hFFFE;
    i_interrupt_disable_instr_lit = 14'h3FFF;
    for (int m = 0; m < 7; m++)
    begin
      i_src_mode = 3'(m);
      i_op2_sel = 2'(m);
      go(0);
      ck("src mem", m != 0, o_src_mem);
      if (m != 0)
        ck("src ea", ea[m], o_src_ea);
      ck("src wb", m == 2 || m == 3, o_src_wb_en);
      if (m == 2 || m == 3)
        ck("wb val", 16'h0FFA, o_src_wb_val);
      ck("dst ea", 16'h2020, o_dst_ea);
      ck("op1", 16'h1357, o_op1);
      ck("op2 mem", m % 4 == 1, o_op2_from_mem);
      if (m % 4 != 1)
        ck("op2", op2[m % 4], o_op2);
    end
    ck("default_working_reg", 1, o_dst_is_default_working_reg);
    ck("offset idx", 4'h3, o_offset_idx);
    ck("dst wb", 0, o_dst_wb_en);
    ck("default_working_reg idx", 0, o_dst_reg_idx);
    ck("branch", 23'h0000FC, o_branch_target);
    ck("interrupt_disable_instr", 14'h3FFF, o_interrupt_disable_instr_count);
  endtask

  task t_mac;
    i_mac_idx_a = 4'h8;
    i_mac_val_a = 16'h1100;
    i_mac_idx_b = 4'hB;
    i_mac_val_b = 16'h1200;
    i_mac_mode_b = `EAG_MAC_IDX;
    i_mac_off = 16'h0010;
    for (int s = 1; s < 4; s++)
    begin
      i_mac_mode_a = 3'(s);
      go(1);
      ck("x addr", 16'h1100, o_x_rd_addr);
      ck("y addr", 16'h1210, o_y_rd_addr);
      ck("x wb", 16'h1100 + 16'(2 * s), o_x_wb_val);
      ck("mac valid", 1, o_mac_valid);
      ck("x idx", 4'h8, o_x_wb_idx);
      ck("x wb en", 1, o_x_wb_en);
      ck("y wb en", 0, o_y_wb_en);
    end
    i_mac_idx_a = 4'hA;
    i_mac_idx_b = 4'h9;
    i_mac_mode_a = `EAG_MAC_IND;
    i_mac_mode_b = `EAG_MAC_IND;
    go(1);
    ck("x swap", 16'h1200, o_x_rd_addr);
    ck("y swap", 16'h1100, o_y_rd_addr);
    i_mac_idx_a = 4'h8;
    go(1);
    ck("mac no y", 0, o_mac_valid);
  endtask

  task t_secure;
    i_src_mode = `EAG_M_IND;
    i_dst_mode = `EAG_M_DIRECT;
    for (int k = 0; k < 6; k++)
    begin
      i_boot_secure_ram_ctl_en = k < 4;
      i_secure_segment_ram_ctl_en = k < 4;
      i_src_ptr = k[1] ? SS : BS;
      i_exec_boot = !k[1] && k[0];
      i_exec_secure = k[1] && k[0];
      go(0);
      ck("ram fault", !k[0] && k < 4, o_ram_fault);
    end
  endtask

  task t_reset;
    @(negedge i_clk);
    i_sys_rst = 1;
    repeat (2) @(negedge i_clk);
    i_sys_rst = 0;
    ck("sp rst", 16'h0800, o_sp);
    ck("limit kept", 16'h0FFE, o_stack_limit);
  endtask

  task wrap_up;
    if (mismatches == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(posedge i_clk);
    @(negedge i_clk);
    i_sys_rst = 0;
    ck("sp rst", 16'h0800, o_sp);
    t_stack;
    t_pc;
    t_modes;
    t_mac;
    t_secure;
    t_reset;
    wrap_up;
  end

  initial
  begin
    #20000;
    mismatches++;
    wrap_up;
  end
endmodule
